// [src/adg_pkg.sv]
// shared constants and types for the address generator datapath
package adg_pkg;
   // widths and counts
   localparam int ADG_AW = 16;
   localparam int ADG_OPTW = 11;
   localparam int ADG_NPTR = 16;
   localparam int ADG_NOFF = 6;
   localparam int ADG_NBND = 4;
   localparam int ADG_OFF_PER_BANK = 3;
   // option word bit positions
   localparam int ADG_OPT_MASK_LO = 0;
   localparam int ADG_OPT_PREC_LO = 4;
   localparam int ADG_OPT_TRANSP = 6;
   localparam int ADG_OPT_PBANK = 7;
   localparam int ADG_OPT_OBANK = 8;
   localparam int ADG_OPT_POST = 9;
   localparam int ADG_OPT_ALTC = 10;
   // codes and reset values
   localparam logic [1:0] ADG_OFF_DATA = 2'h3;
   localparam logic [10:0] ADG_OPT_RESET = 11'h000;
   localparam logic [15:0] ADG_ONE = 16'h0001;
   localparam logic [15:0] ADG_ZERO = 16'h0000;
   localparam logic [4:0] ADG_OPT_PAD = 5'h00;

   typedef enum logic [3:0] {
      ALU_NONE, ALU_ADD, ALU_SUB, ALU_OR, ALU_AND, ALU_XOR,
      ALU_INC, ALU_DEC, ALU_SHL, ALU_SHR
   } adg_aluop_t;

   typedef enum logic [2:0] {
      RK_POINTER, RK_OFFSET, RK_BOUND, RK_RESTART, RK_OPTION
   } adg_regkind_t;

   typedef enum logic [1:0] {
      OW_NONE, OW_LOAD, OW_SET, OW_CLEAR
   } adg_optop_t;
endpackage

// [src/adg_alu.sv]
// arithmetic, logic and single-bit shift unit
module adg_alu
   import adg_pkg::*;
(
   // operation
   input wire adg_aluop_t op,
   input wire logic [ADG_AW-1:0] opA,
   input wire logic [ADG_AW-1:0] opB,
   // results
   output logic [ADG_AW-1:0] result,
   output logic logicZero,
   output logic increasing
);
   // sums wrap at the port width, no carry kept
   always_comb begin
      result = opA;
      case (op)
         ALU_ADD: result = opA + opB;
         ALU_SUB: result = opA - opB;
         ALU_OR: result = opA | opB;
         ALU_AND: result = opA & opB;
         ALU_XOR: result = opA ^ opB;
         ALU_INC: result = opA + ADG_ONE;
         ALU_DEC: result = opA - ADG_ONE;
         ALU_SHL: result = {opA[ADG_AW-2:0], 1'b0};
         ALU_SHR: result = {opA[ADG_AW-1], opA[ADG_AW-1:1]};
         default: result = opA;
      endcase
   end

   // zero detect only means something for the logic ops
   assign logicZero = (op == ALU_OR || op == ALU_AND || op == ALU_XOR)
      && (result == ADG_ZERO);
   // decreasing updates treat the boundary as a lower limit
   assign increasing = !(op == ALU_SUB || op == ALU_DEC);
endmodule

// [src/adg_cmp.sv]
// unsigned boundary comparator for circular buffers
module adg_cmp
   import adg_pkg::*;
(
   // values
   input wire logic [ADG_AW-1:0] addr,
   input wire logic [ADG_AW-1:0] bound,
   input wire logic increasing,
   // result
   output logic hit
);
   // both sides unsigned, so all-ones is the largest address
   assign hit = increasing ? (addr >= bound) : (addr <= bound);
endmodule

// [src/adg_datapath.sv]
// address generator datapath: pointers, offsets, alu, compare, output
//
// How it works
// - six sixteen-bit offset registers in two banks of three feed updates.
// - offset code 00-10 picks a bank register; code 11 takes the data port.
// - option bit 8 picks the upper offset bank when set, else lower.
// - short-pointer add/subtract use option bit 7 as the pointer bank bit.
// - alu adds, subtracts, ors, ands, xors, increments, decrements, shifts.
// - operands are pointer and offset; data port may replace one or both.
// - shifts move one bit; left fills zero, right copies the sign.
// - a zero result of or, and, xor raises the compare/zero flag when compare is off.
// - four boundary registers pair with four restart registers by index.
// - comparing ops reload the pointer from restart when boundary reached.
// - limit direction follows the op; a hit drives the flag pin too.
// - the comparator looks at the address actually driven out.
// - option bits 3-0 enable reload per index; cleared means never.
// - output address comes from pointer or data port, raw or updated.
// - latched mode captures the address and holds it through the cycle.
// - option bit 6 makes the output follow every cycle, not held.
// - address outputs are released whenever no address is output.
// - the bit reverser mirrors the sixteen address bits about the centre.
// - option word loads from data bits 10-0 or bit by bit.
// - option bits 5-4 hold the two-bit precision code.
// - option bit 9 outputs after update, else before update.
// - option bit 10 turns a hit into alternate slot enable, no reload.
// - boundary comparison is unsigned sixteen bit.
// - increasing ops hit at greater-or-equal, decreasing at less-or-equal.
// - data port is sampled on the edge and driven one cycle per read.
module adg_datapath
   import adg_pkg::*;
#(
   parameter int NPTR = ADG_NPTR,
   parameter int NOFF = ADG_NOFF,
   parameter int NBND = ADG_NBND
)(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // decoded addressing operation
   input wire logic outEn,
   input wire adg_aluop_t aluOp,
   input wire logic [3:0] ptrSel,
   input wire logic shortPtr,
   input wire logic ptrFromData,
   input wire logic [1:0] offSel,
   input wire logic compareEn,
   input wire logic [1:0] bndSel,
   input wire logic bitRevEn,
   // register moves through the data port
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire adg_regkind_t regKind,
   input wire logic [3:0] regIdx,
   input wire adg_optop_t optOp,
   input wire logic [3:0] optBit,
   // data port, split into its three signals
   input wire logic [ADG_AW-1:0] dataIn,
   output logic [ADG_AW-1:0] dataOut,
   output logic dataOe,
   // address port and flags
   output logic [ADG_AW-1:0] addrOut,
   output logic addrOe,
   output logic boundaryZeroFlag,
   output logic alternateSlotEn,
   output logic [1:0] precisionMode
);
   logic [ADG_AW-1:0] ptrBank_r [NPTR];
   logic [ADG_AW-1:0] offBank_r [NOFF];
   logic [ADG_AW-1:0] bound_r [NBND];
   logic [ADG_AW-1:0] restart_r [NBND];
   logic [ADG_OPTW-1:0] optionControlWord_r;
   logic [ADG_AW-1:0] addrOut_r;
   logic addrOe_r;
   logic flag_r;
   logic altSlot_r;
   logic [ADG_AW-1:0] dataOut_r;
   logic dataOe_r;
   logic [3:0] ptrIdx;
   logic [2:0] offIdx;
   logic [ADG_AW-1:0] opA;
   logic [ADG_AW-1:0] opB;
   logic [ADG_AW-1:0] updated;
   logic logicZero;
   logic increasing;
   logic [ADG_AW-1:0] yRaw;
   logic [ADG_AW-1:0] yRev;
   logic [ADG_AW-1:0] yDrv;
   logic cmpHit;
   logic reloadOk;
   logic doReload;
   logic doUpdate;
   logic [ADG_AW-1:0] ptrNxt;
   logic [ADG_AW-1:0] readVal;

   // pointer index; short form borrows the bank bit
   assign ptrIdx = shortPtr
      ? {optionControlWord_r[ADG_OPT_PBANK], ptrSel[2:0]}
      : ptrSel;

   // offset index within the selected bank
   assign offIdx = optionControlWord_r[ADG_OPT_OBANK]
      ? 3'(ADG_OFF_PER_BANK) + {1'b0, offSel}
      : {1'b0, offSel};

   // operand steering; data port can supply either or both sides
   assign opA = ptrFromData ? dataIn : ptrBank_r[ptrIdx];
   assign opB = (offSel == ADG_OFF_DATA) ? dataIn : offBank_r[offIdx];

   adg_alu u_alu (
      .op(aluOp),
      .opA(opA),
      .opB(opB),
      .result(updated),
      .logicZero(logicZero),
      .increasing(increasing)
   );

   // output order: before or after the update
   assign yRaw = optionControlWord_r[ADG_OPT_POST] ? updated : opA;

   // mirror the address about its centre
   for (genvar i = 0; i < ADG_AW; i++) begin : g_rev
      assign yRev[i] = yRaw[ADG_AW-1-i];
   end

   assign yDrv = bitRevEn ? yRev : yRaw;

   // the comparator sees exactly what leaves the address port
   adg_cmp u_cmp (
      .addr(yDrv),
      .bound(bound_r[bndSel]),
      .increasing(increasing),
      .hit(cmpHit)
   );

   // reload gated by the per-index mask and the alternate slot mode
   assign reloadOk = optionControlWord_r[bndSel]
      && !optionControlWord_r[ADG_OPT_ALTC];
   assign doReload = compareEn && cmpHit && reloadOk;
   assign doUpdate = (aluOp != ALU_NONE);
   assign ptrNxt = doReload ? restart_r[bndSel] : updated;

   // pointer file; an update wins over a plain register write
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int k = 0; k < NPTR; k++) begin
            ptrBank_r[k] <= ADG_ZERO;
         end
      end else if (doUpdate) begin
         ptrBank_r[ptrIdx] <= ptrNxt;
      end else if (regWrEn && regKind == RK_POINTER) begin
         ptrBank_r[regIdx] <= dataIn;
      end
   end

   // offset registers, two banks of three
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int k = 0; k < NOFF; k++) begin
            offBank_r[k] <= ADG_ZERO;
         end
      end else if (regWrEn && regKind == RK_OFFSET
            && int'(regIdx) < NOFF) begin
         offBank_r[regIdx[2:0]] <= dataIn;
      end
   end

   // boundary and restart pairs share one index
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int k = 0; k < NBND; k++) begin
            bound_r[k] <= ADG_ZERO;
            restart_r[k] <= ADG_ZERO;
         end
      end else if (regWrEn && regKind == RK_BOUND) begin
         bound_r[regIdx[1:0]] <= dataIn;
      end else if (regWrEn && regKind == RK_RESTART) begin
         restart_r[regIdx[1:0]] <= dataIn;
      end
   end

   // option word: full load or single bit set and clear
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         optionControlWord_r <= ADG_OPT_RESET;
      end else if (optOp == OW_LOAD) begin
         optionControlWord_r <= dataIn[ADG_OPTW-1:0];
      end else if (optOp == OW_SET && int'(optBit) < ADG_OPTW) begin
         optionControlWord_r[optBit] <= 1'b1;
      end else if (optOp == OW_CLEAR && int'(optBit) < ADG_OPTW) begin
         optionControlWord_r[optBit] <= 1'b0;
      end
   end

   // address port; latched mode holds between outputs
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         addrOut_r <= ADG_ZERO;
         addrOe_r <= 1'b0;
      end else begin
         addrOe_r <= outEn;
         if (outEn || optionControlWord_r[ADG_OPT_TRANSP]) begin
            addrOut_r <= yDrv;
         end
      end
   end

   // flag pin carries the compare hit or the logic zero
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flag_r <= 1'b0;
      end else begin
         flag_r <= compareEn ? cmpHit : logicZero;
      end
   end

   // alternate slot enable for the following cycle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         altSlot_r <= 1'b0;
      end else begin
         altSlot_r <= compareEn && cmpHit
            && optionControlWord_r[ADG_OPT_ALTC];
      end
   end

   // read source mux; unused upper option bits read as zero
   always_comb begin
      readVal = ADG_ZERO;
      case (regKind)
         RK_POINTER: readVal = ptrBank_r[regIdx];
         RK_OFFSET: readVal = (int'(regIdx) < NOFF)
            ? offBank_r[regIdx[2:0]] : ADG_ZERO;
         RK_BOUND: readVal = bound_r[regIdx[1:0]];
         RK_RESTART: readVal = restart_r[regIdx[1:0]];
         RK_OPTION: readVal = {ADG_OPT_PAD, optionControlWord_r};
         default: readVal = ADG_ZERO;
      endcase
   end

   // data port driven for exactly one cycle per read, then released
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dataOut_r <= ADG_ZERO;
         dataOe_r <= 1'b0;
      end else begin
         dataOe_r <= regRdEn;
         if (regRdEn) begin
            dataOut_r <= readVal;
         end
      end
   end

   assign dataOut = dataOut_r;
   assign dataOe = dataOe_r;
   assign addrOut = addrOut_r;
   assign addrOe = addrOe_r;
   assign boundaryZeroFlag = flag_r;
   assign alternateSlotEn = altSlot_r;
   // precision code is exported straight from the option word
   assign precisionMode = optionControlWord_r[ADG_OPT_PREC_LO+1:
      ADG_OPT_PREC_LO];

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence readReq;
      regRdEn ##1 !regRdEn;
   endsequence
   sequence driveOnce;
      dataOe ##1 !dataOe;
   endsequence

   data_drive_a: assert property (readReq |-> driveOnce)
      else $error("data port not driven for exactly one cycle");
   offset_data_a: assert property (offSel == ADG_OFF_DATA |-> opB == dataIn)
      else $error("offset code 11 did not select data port");
   offset_bank_a: assert property (offSel == 2'h0
      && optionControlWord_r[ADG_OPT_OBANK] |-> opB == offBank_r[3])
      else $error("upper offset bank not selected");
   ptr_bank_a: assert property (shortPtr |-> ptrIdx[3]
      == optionControlWord_r[ADG_OPT_PBANK])
      else $error("pointer bank bit not applied");
   shift_fill_a: assert property (aluOp == ALU_SHR
      |-> updated[ADG_AW-1] == opA[ADG_AW-1]
      && updated[ADG_AW-2:0] == opA[ADG_AW-1:1])
      else $error("arithmetic right shift wrong");
   zero_flag_a: assert property (!compareEn && aluOp == ALU_XOR
      && opA == opB |=> boundaryZeroFlag)
      else $error("zero result did not raise flag");
   reload_restart_a: assert property (doUpdate && compareEn && cmpHit
      && reloadOk && !ptrFromData |=> ptrBank_r[$past(ptrIdx)]
      == $past(restart_r[bndSel]))
      else $error("pointer not reloaded from restart");
   mask_block_a: assert property (doUpdate && compareEn
      && !optionControlWord_r[bndSel]
      |=> ptrBank_r[$past(ptrIdx)] == $past(updated))
      else $error("masked index still reloaded");
   alt_slot_a: assert property (compareEn && cmpHit && doUpdate
      && optionControlWord_r[ADG_OPT_ALTC] |=> alternateSlotEn
      && ptrBank_r[$past(ptrIdx)] == $past(updated))
      else $error("alternate slot mode misbehaved");
   addr_release_a: assert property (!outEn |=> !addrOe)
      else $error("address driven without output");
   latched_hold_a: assert property (!outEn
      && !optionControlWord_r[ADG_OPT_TRANSP] |=> $stable(addrOut))
      else $error("latched address did not hold");
   post_order_a: assert property (outEn && !bitRevEn
      && optionControlWord_r[ADG_OPT_POST] |=> addrOut == $past(updated))
      else $error("post-update address not output");
   option_load_a: assert property (optOp == OW_LOAD
      |=> {ADG_OPT_PAD, optionControlWord_r} == ($past(dataIn)
      & 16'h07FF))
      else $error("option word load wrong");
   flag_dir_a: assert property (compareEn && aluOp == ALU_DEC
      && yDrv < bound_r[bndSel] |=> boundaryZeroFlag)
      else $error("decreasing compare missed lower limit");
endmodule

// [verif/adg_mem_model.sv]
// far side model: data port wire and memory address bus
module adg_mem_model
   import adg_pkg::*;
(
   // clock
   input wire logic clk,
   // device side
   input wire logic [ADG_AW-1:0] dataOut,
   input wire logic dataOe,
   input wire logic [ADG_AW-1:0] addrOut,
   input wire logic addrOe,
   // bench side of the data wire
   input wire logic [ADG_AW-1:0] tbData,
   input wire logic tbDrive,
   // resolved levels
   output logic [ADG_AW-1:0] dataWire,
   output logic [ADG_AW-1:0] memAddr
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [ADG_AW-1:0] lastData = 16'h0000;
   logic [ADG_AW-1:0] lastAddr = 16'h0000;
   // released wire shows the inverse, never a stale match
   always_comb begin
      if (dataOe) begin
         dataWire = dataOut;
      end else if (tbDrive) begin
         dataWire = tbData;
      end else begin
         dataWire = ~lastData;
      end
   end
   // floating address bus flips every cycle
   assign memAddr = addrOe ? addrOut : ~lastAddr;
   always @(posedge clk) begin
      lastData <= dataWire;
      lastAddr <= memAddr;
   end
endmodule

// [verif/adg_tb.sv]
// self-checking bench for the address generator datapath
module tb
   import adg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_b, outEn, shortPtr, ptrFromData, compareEn, bitRevEn;
   logic regWrEn, regRdEn, dataOe, addrOe, boundaryZeroFlag;
   logic alternateSlotEn, tbDrive;
   logic [3:0] ptrSel, regIdx, optBit;
   logic [1:0] offSel, bndSel, precisionMode;
   logic [15:0] dataIn, dataOut, addrOut, tbData, memAddr;
   adg_aluop_t aluOp;
   adg_regkind_t regKind;
   adg_optop_t optOp;
   int failCount = 0;
   int comparisons = 0;
   // pointer F0F1, upper offsets 1003..1005, post mode
   adg_aluop_t aluT [9] = '{ALU_ADD, ALU_SUB, ALU_OR, ALU_AND, ALU_XOR,
      ALU_INC, ALU_DEC, ALU_SHL, ALU_SHR};
   logic [1:0] offT [9] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h0, 2'h0,
      2'h0, 2'h0};
   logic [15:0] expT [9] = '{16'h00F4, 16'hE0ED, 16'hF0F5, 16'h0000,
      16'h0000, 16'hF0F2, 16'hF0F0, 16'hE1E2, 16'hF878};
   logic [8:0] flagT = 9'h018;

   adg_datapath u_adg_datapath (.clk(clk), .rst_b(rst_b), .outEn(outEn),
      .aluOp(aluOp), .ptrSel(ptrSel), .shortPtr(shortPtr),
      .ptrFromData(ptrFromData), .offSel(offSel), .compareEn(compareEn),
      .bndSel(bndSel), .bitRevEn(bitRevEn), .regWrEn(regWrEn),
      .regRdEn(regRdEn), .regKind(regKind), .regIdx(regIdx),
      .optOp(optOp), .optBit(optBit), .dataIn(dataIn), .dataOut(dataOut),
      .dataOe(dataOe), .addrOut(addrOut), .addrOe(addrOe),
      .boundaryZeroFlag(boundaryZeroFlag),
      .alternateSlotEn(alternateSlotEn), .precisionMode(precisionMode));
   adg_mem_model u_adg_mem_model (.clk(clk), .dataOut(dataOut),
      .dataOe(dataOe), .addrOut(addrOut), .addrOe(addrOe), .tbData(tbData),
      .tbDrive(tbDrive), .dataWire(dataIn), .memAddr(memAddr));

   // free-running clock, 8 ns
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // a hung run still ends through the same report
   initial begin
      repeat (5000) @(posedge clk);
      failCount++;
      final_report();
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         failCount++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one place sets every strobe, so none is written twice per step
   task automatic strobes(input logic w, input logic r, input logic e,
      input adg_optop_t oo, input adg_aluop_t a, input logic c);
      regWrEn = w;
      regRdEn = r;
      outEn = e;
      optOp = oo;
      aluOp = a;
      compareEn = c;
   endtask
   task automatic idle();
      strobes(1'b0, 1'b0, 1'b0, OW_NONE, ALU_NONE, 1'b0);
      tbDrive = 1'b0;
      @(negedge clk);
   endtask
   task automatic wr(input adg_regkind_t k, input logic [3:0] i,
      input logic [15:0] d);
      strobes(1'b1, 1'b0, 1'b0, OW_NONE, ALU_NONE, 1'b0);
      regKind = k;
      regIdx = i;
      tbDrive = 1'b1;
      tbData = d;
      @(negedge clk);
   endtask
   task automatic optw(input adg_optop_t o, input logic [3:0] b,
      input logic [15:0] d);
      strobes(1'b0, 1'b0, 1'b0, o, ALU_NONE, 1'b0);
      optBit = b;
      tbDrive = 1'b1;
      tbData = d;
      @(negedge clk);
   endtask
   task automatic rd(input adg_regkind_t k, input logic [3:0] i,
      input logic [15:0] exp);
      strobes(1'b0, 1'b1, 1'b0, OW_NONE, ALU_NONE, 1'b0);
      regKind = k;
      regIdx = i;
      tbDrive = 1'b0;
      @(negedge clk);
      chk(16'(dataOe), 16'h0001);
      chk(dataIn, exp);
      // let the read answer drop before anyone drives the wire again
      idle();
      chk(16'(dataOe), 16'h0000);
   endtask
   task automatic op(input adg_aluop_t a, input logic [3:0] p,
      input logic [1:0] o, input logic c, input logic [15:0] d,
      input logic [15:0] ea, input logic ef);
      strobes(1'b0, 1'b0, 1'b1, OW_NONE, a, c);
      ptrSel = p;
      offSel = o;
      tbDrive = 1'b1;
      tbData = d;
      @(negedge clk);
      chk(memAddr, ea);
      chk(16'(boundaryZeroFlag), 16'(ef));
   endtask
   task automatic endTest(input string name);
      $display("test %s finished", name);
   endtask
   task automatic final_report();
      $display("counts: %0d comparisons, %0d mismatches", comparisons,
         failCount);
      if (failCount == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      rst_b = 1'b0;
      strobes(1'b0, 1'b0, 1'b0, OW_NONE, ALU_NONE, 1'b0);
      {shortPtr, ptrFromData, bitRevEn, tbDrive} = 4'h0;
      {ptrSel, regIdx, optBit, offSel, bndSel} = 16'h0000;
      regKind = RK_POINTER;
      tbData = 16'h0000;
      repeat (3) @(negedge clk);
      chk(16'({addrOe, dataOe}), 16'h0000);
      rst_b = 1'b1;
      rd(RK_OPTION, 4'h0, 16'h0000);
      optw(OW_LOAD, 4'h0, 16'hFFFF);
      rd(RK_OPTION, 4'h0, 16'h07FF);
      chk(16'(precisionMode), 16'h0003);
      optw(OW_CLEAR, 4'h4, 16'h0000);
      optw(OW_SET, 4'hB, 16'h0000);
      rd(RK_OPTION, 4'h0, 16'h07EF);
      chk(16'(precisionMode), 16'h0002);
      idle();
      chk(16'(dataOe), 16'h0000);
      endTest("option word");
      for (int i = 0; i < 6; i++) wr(RK_OFFSET, 4'(i), 16'h1000 + 16'(i));
      for (int i = 0; i < 4; i++) begin
         wr(RK_BOUND, 4'(i), 16'h2000 + 16'(i));
         wr(RK_RESTART, 4'(i), 16'h3000 + 16'(i));
      end
      for (int i = 0; i < 6; i++) begin
         rd(RK_OFFSET, 4'(i), 16'h1000 + 16'(i));
      end
      rd(RK_OFFSET, 4'h6, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         rd(RK_BOUND, 4'(i), 16'h2000 + 16'(i));
         rd(RK_RESTART, 4'(i), 16'h3000 + 16'(i));
      end
      endTest("register file");
      optw(OW_LOAD, 4'h0, 16'h0300);
      for (int i = 0; i < 9; i++) begin
         wr(RK_POINTER, 4'h2, 16'hF0F1);
         op(aluT[i], 4'h2, offT[i], 1'b0, (i == 3) ? 16'h0F0E : 16'hF0F1,
            expT[i], flagT[i]);
      end
      rd(RK_POINTER, 4'h2, 16'hF878);
      endTest("alu");
      optw(OW_LOAD, 4'h0, 16'h0004);
      wr(RK_BOUND, 4'h2, 16'h0F06);
      wr(RK_RESTART, 4'h2, 16'h0EFF);
      wr(RK_POINTER, 4'h1, 16'h0F05);
      bndSel = 2'h2;
      op(ALU_INC, 4'h1, 2'h0, 1'b1, 16'h0000, 16'h0F05, 1'b0);
      op(ALU_INC, 4'h1, 2'h0, 1'b1, 16'h0000, 16'h0F06, 1'b1);
      op(ALU_INC, 4'h1, 2'h0, 1'b1, 16'h0000, 16'h0EFF, 1'b0);
      idle();
      chk(16'(addrOe), 16'h0000);
      chk(addrOut, 16'h0EFF);
      op(ALU_DEC, 4'h1, 2'h0, 1'b1, 16'h0000, 16'h0F00, 1'b1);
      op(ALU_DEC, 4'h1, 2'h0, 1'b1, 16'h0000, 16'h0EFF, 1'b1);
      optw(OW_LOAD, 4'h0, 16'h0000);
      wr(RK_POINTER, 4'h1, 16'h0F06);
      op(ALU_INC, 4'h1, 2'h0, 1'b1, 16'h0000, 16'h0F06, 1'b1);
      op(ALU_INC, 4'h1, 2'h0, 1'b1, 16'h0000, 16'h0F07, 1'b1);
      optw(OW_LOAD, 4'h0, 16'h0404);
      wr(RK_POINTER, 4'h1, 16'h0F06);
      op(ALU_INC, 4'h1, 2'h0, 1'b1, 16'h0000, 16'h0F06, 1'b1);
      chk(16'(alternateSlotEn), 16'h0001);
      op(ALU_INC, 4'h1, 2'h0, 1'b1, 16'h0000, 16'h0F07, 1'b1);
      optw(OW_LOAD, 4'h0, 16'h0204);
      wr(RK_POINTER, 4'h1, 16'h0F05);
      op(ALU_INC, 4'h1, 2'h0, 1'b1, 16'h0000, 16'h0F06, 1'b1);
      op(ALU_INC, 4'h1, 2'h0, 1'b1, 16'h0000, 16'h0F00, 1'b0);
      endTest("circular buffer");
      optw(OW_LOAD, 4'h0, 16'h0080);
      wr(RK_POINTER, 4'h9, 16'h0100);
      shortPtr = 1'b1;
      op(ALU_ADD, 4'h1, 2'h0, 1'b0, 16'h0000, 16'h0100, 1'b0);
      shortPtr = 1'b0;
      rd(RK_POINTER, 4'h9, 16'h1100);
      wr(RK_POINTER, 4'h3, 16'h0001);
      bitRevEn = 1'b1;
      op(ALU_NONE, 4'h3, 2'h0, 1'b0, 16'h0000, 16'h8000, 1'b0);
      bitRevEn = 1'b0;
      optw(OW_LOAD, 4'h0, 16'h0200);
      ptrFromData = 1'b1;
      op(ALU_INC, 4'h4, 2'h0, 1'b0, 16'h1234, 16'h1235, 1'b0);
      ptrFromData = 1'b0;
      rd(RK_POINTER, 4'h4, 16'h1235);
      // transparent mode: address follows the pointer with no output cycle
      optw(OW_LOAD, 4'h0, 16'h0040);
      wr(RK_POINTER, 4'h4, 16'h0ABC);
      idle();
      chk(addrOut, 16'h0ABC);
      endTest("address sources");
      final_report();
   end
endmodule
